// >>> design/gccw_pkg.sv
/*
 * Package for the grid converter command word interpreter: register map,
 * command word bit positions, reset values and shared types.
 * Assumes an AXI4-Lite host with 32-bit data and byte addressing.
 */
package gccw_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_COMMAND = 8'h00;
   localparam logic [7:0] OFS_CONFIG  = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_EVENT   = 8'h0c;
   localparam logic [7:0] OFS_MASK    = 8'h10;

   // ----------------------------------------------------------------
   // Command word bit positions
   // ----------------------------------------------------------------
   localparam int BIT_SW_ON_EN   = 0;
   localparam int BIT_BRK_EN     = 1;
   localparam int BIT_QSTOP_N    = 2;
   localparam int BIT_START      = 3;
   localparam int BIT_PRECHARGE  = 4;
   localparam int BIT_EVT_RESET  = 7;
   localparam int BIT_DATA_VALID = 10;

   // Configuration register bit positions
   localparam int CFG_EDGE_START = 0;
   localparam int CFG_APP_PRECH  = 1;
   localparam int CFG_QS_EXCEPT  = 2;
   localparam int CFG_WDOG_FAULT = 3;

   // Event bit positions
   localparam int EV_FAULT_ACK = 0;
   localparam int EV_QSTOP     = 1;
   localparam int EV_TRIP      = 2;
   localparam int EV_RUN       = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] CMD_DEFAULT = 16'h0005;
   localparam logic [3:0]  CFG_RESET   = 4'h0;
   localparam logic [3:0]  MASK_RESET  = 4'h0;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_SWITCH_ON_INHIBITED,
      ST_READY_TO_SWITCH_ON,
      ST_PRECHARGING,
      ST_BREAKER_CLOSING,
      ST_RUNNING
   } gccw_state_e;

   // Outputs toward the power stage
   typedef struct packed {
      logic precharge;
      logic main_breaker_close;
      logic modulate;
      logic exception;
      logic fault_ack;
   } gccw_ctrl_s;

   // Feedback from the power stage
   typedef struct packed {
      logic precharge_done;
      logic main_breaker_closed;
      logic fault_active;
   } gccw_fbk_s;

endpackage : gccw_pkg

// >>> design/gccw_top.sv
/*
 * Grid converter command word interpreter with AXI4-Lite register access.
 * Assumes a single 40 MHz clock, power stage feedback synchronous to it,
 * and a host that keeps at most one read and one write outstanding.
 */
`timescale 1ns/1ps

module gccw_top (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               resetn,
   input  wire logic               clk_en,
   // AXI4-Lite write address
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // Power stage
   input  wire gccw_pkg::gccw_fbk_s  fbk,
   output gccw_pkg::gccw_ctrl_s      ctrl,
   // Interrupt
   output logic                    irq
);

   // ----------------------------------------------------------------
   // Register file state
   // ----------------------------------------------------------------
   logic [15:0]             cmd_raw_q;    // Word as last written
   logic [15:0]             cmd_held_q;   // Last word seen with data valid
   logic [15:0]             cmd_prev_q;
   logic [3:0]              cfg_q;
   logic [3:0]              evt_q;
   logic [3:0]              mask_q;
   logic [7:0]              awaddr_q;
   logic [31:0]             wdata_q;
   logic                    aw_have_q;
   logic                    w_have_q;
   gccw_pkg::gccw_state_e   state_q;
   logic                    sw_on_seen_low_q;
   logic                    start_armed_q;
   gccw_pkg::gccw_ctrl_s    ctrl_q;

   // Register address check, used by both read and write paths
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == gccw_pkg::OFS_COMMAND) || (a == gccw_pkg::OFS_CONFIG) ||
               (a == gccw_pkg::OFS_STATUS)  || (a == gccw_pkg::OFS_EVENT)  ||
               (a == gccw_pkg::OFS_MASK);
   endfunction

   // ----------------------------------------------------------------
   // Write channel capture
   // ----------------------------------------------------------------
   logic wr_fire;
   // Readies drop while frozen, so no beat is taken that the state cannot hold
   assign s_axi_awready = clk_en && !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = clk_en && !w_have_q && !s_axi_bvalid;
   assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;

   // Address and data may arrive in either order
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;   // Strobes ignored: whole-word registers
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // Write response, error on unmapped address
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= gccw_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_q) ? gccw_pkg::RESP_OKAY : gccw_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Command word intake
   // ----------------------------------------------------------------
   logic        wr_cmd;
   logic [15:0] cmd;
   logic [15:0] rise;
   assign wr_cmd = wr_fire && (awaddr_q == gccw_pkg::OFS_COMMAND);

   // Raw word, plus the held copy that only follows while valid
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cmd_raw_q  <= gccw_pkg::CMD_DEFAULT;
         cmd_held_q <= gccw_pkg::CMD_DEFAULT;
      end else if (clk_en) begin
         if (wr_cmd) begin
            cmd_raw_q <= wdata_q[15:0];
            if (wdata_q[gccw_pkg::BIT_DATA_VALID])
               cmd_held_q <= wdata_q[15:0];
         end
      end
   end

   // Watchdog fault overrides with the default word; bits 5 and 6 are unused
   assign cmd = ((cfg_q[gccw_pkg::CFG_WDOG_FAULT]) ? gccw_pkg::CMD_DEFAULT
                 : cmd_held_q) & 16'hff9f;

   // Previous word for edge detection
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         cmd_prev_q <= gccw_pkg::CMD_DEFAULT;
      else if (clk_en)
         cmd_prev_q <= cmd;
   end
   assign rise = cmd & ~cmd_prev_q;

   // ----------------------------------------------------------------
   // Decoded controls
   // ----------------------------------------------------------------
   logic sw_on, brk_en, qstop, start, start_rise, evt_rise, permit;
   assign sw_on      = cmd[gccw_pkg::BIT_SW_ON_EN];
   assign brk_en     = cmd[gccw_pkg::BIT_BRK_EN];
   assign qstop      = !cmd[gccw_pkg::BIT_QSTOP_N];
   assign start      = cmd[gccw_pkg::BIT_START];
   assign start_rise = rise[gccw_pkg::BIT_START];
   assign evt_rise   = rise[gccw_pkg::BIT_EVT_RESET];
   // Both enables and no fault needed for any forward step
   assign permit     = sw_on && brk_en && !fbk.fault_active;

   // ----------------------------------------------------------------
   // Sequencing state machine
   // ----------------------------------------------------------------
   // Switch-on enable must be seen low before leaving the inhibited state
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         sw_on_seen_low_q <= 1'b0;
      else if (clk_en) begin
         if (!sw_on)
            sw_on_seen_low_q <= 1'b1;
         else if (state_q != gccw_pkg::ST_SWITCH_ON_INHIBITED)
            sw_on_seen_low_q <= 1'b0;
      end
   end

   // Edge-start arming: an edge that cannot start is discarded
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         start_armed_q <= 1'b0;
      else if (clk_en) begin
         if (start_rise && state_q == gccw_pkg::ST_READY_TO_SWITCH_ON && permit && !qstop)
            start_armed_q <= 1'b1;
         else if (!start || state_q == gccw_pkg::ST_SWITCH_ON_INHIBITED)
            start_armed_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         state_q <= gccw_pkg::ST_SWITCH_ON_INHIBITED;
      else if (clk_en) begin
         if (!sw_on || !brk_en || fbk.fault_active) begin
            state_q <= gccw_pkg::ST_SWITCH_ON_INHIBITED;
         end else begin
            case (state_q)
               gccw_pkg::ST_SWITCH_ON_INHIBITED:
                  if (sw_on_seen_low_q && !qstop)
                     state_q <= gccw_pkg::ST_READY_TO_SWITCH_ON;
               gccw_pkg::ST_READY_TO_SWITCH_ON:
                  if (start_rise && !qstop)
                     state_q <= gccw_pkg::ST_PRECHARGING;
               gccw_pkg::ST_PRECHARGING:
                  if (!start || qstop)
                     state_q <= gccw_pkg::ST_READY_TO_SWITCH_ON;
                  else if (fbk.precharge_done)
                     state_q <= gccw_pkg::ST_BREAKER_CLOSING;
               gccw_pkg::ST_BREAKER_CLOSING:
                  if (!start || qstop)
                     state_q <= gccw_pkg::ST_READY_TO_SWITCH_ON;
                  else if (fbk.main_breaker_closed &&
                           (!cfg_q[gccw_pkg::CFG_EDGE_START] || start_armed_q))
                     state_q <= gccw_pkg::ST_RUNNING;
               gccw_pkg::ST_RUNNING:
                  if (!start || qstop)
                     state_q <= gccw_pkg::ST_READY_TO_SWITCH_ON;
               default:
                  state_q <= gccw_pkg::ST_SWITCH_ON_INHIBITED;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Power stage outputs, registered
   // ----------------------------------------------------------------
   logic in_seq;
   assign in_seq = (state_q == gccw_pkg::ST_PRECHARGING) ||
                   (state_q == gccw_pkg::ST_BREAKER_CLOSING) ||
                   (state_q == gccw_pkg::ST_RUNNING);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         ctrl_q <= '0;
      else if (clk_en) begin
         // Application may take precharge over through bit 4
         ctrl_q.precharge <= permit && (cfg_q[gccw_pkg::CFG_APP_PRECH]
                             ? cmd[gccw_pkg::BIT_PRECHARGE]
                             : state_q == gccw_pkg::ST_PRECHARGING);
         ctrl_q.main_breaker_close <= permit &&
                  (state_q == gccw_pkg::ST_BREAKER_CLOSING ||
                   state_q == gccw_pkg::ST_RUNNING);
         ctrl_q.modulate  <= permit && start && !qstop &&
                             state_q == gccw_pkg::ST_RUNNING;
         // Exception holds as a level until quick stop is withdrawn
         ctrl_q.exception <= cfg_q[gccw_pkg::CFG_QS_EXCEPT] && qstop &&
                             (in_seq || ctrl_q.exception);
         ctrl_q.fault_ack <= evt_rise;
      end
   end
   assign ctrl = ctrl_q;

   // ----------------------------------------------------------------
   // Configuration, events and mask
   // ----------------------------------------------------------------
   logic [3:0] evt_set;
   assign evt_set = {ctrl_q.modulate, !sw_on && in_seq,
                     qstop && in_seq, evt_rise};

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cfg_q  <= gccw_pkg::CFG_RESET;
         mask_q <= gccw_pkg::MASK_RESET;
      end else if (clk_en && wr_fire) begin
         if (awaddr_q == gccw_pkg::OFS_CONFIG) cfg_q  <= wdata_q[3:0];
         if (awaddr_q == gccw_pkg::OFS_MASK)   mask_q <= wdata_q[3:0];
      end
   end

   // Write one to clear; a fresh event in the same cycle wins
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         evt_q <= 4'h0;
      else if (clk_en) begin
         if (wr_fire && awaddr_q == gccw_pkg::OFS_EVENT)
            evt_q <= (evt_q & ~wdata_q[3:0]) | evt_set;
         else
            evt_q <= evt_q | evt_set;
      end
   end
   assign irq = |(evt_q & mask_q);

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   assign s_axi_arready = clk_en && !s_axi_rvalid;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= gccw_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? gccw_pkg::RESP_OKAY
                                                 : gccw_pkg::RESP_SLVERR;
            case (s_axi_araddr)
               gccw_pkg::OFS_COMMAND: s_axi_rdata <= {16'h0000, cmd_raw_q};
               gccw_pkg::OFS_CONFIG:  s_axi_rdata <= {28'h0000000, cfg_q};
               gccw_pkg::OFS_STATUS:  s_axi_rdata <= {cmd, 8'h00,
                                        ctrl_q[4:1], 1'b0, state_q};
               gccw_pkg::OFS_EVENT:   s_axi_rdata <= {28'h0000000, evt_q};
               gccw_pkg::OFS_MASK:    s_axi_rdata <= {28'h0000000, mask_q};
               default:               s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_enable_drop_inhibits: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && !sw_on) |=> state_q == gccw_pkg::ST_SWITCH_ON_INHIBITED)
      else $error("switch-on enable low did not inhibit");
   a_breaker_drop_opens: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && !brk_en) |=> !ctrl_q.main_breaker_close && !ctrl_q.modulate)
      else $error("breaker enable low left breaker closed");
   a_leave_needs_low: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == gccw_pkg::ST_SWITCH_ON_INHIBITED && !sw_on_seen_low_q)
      |=> state_q == gccw_pkg::ST_SWITCH_ON_INHIBITED)
      else $error("left inhibited without enable seen low");
   a_quick_stop_mod: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && qstop) |=> !ctrl_q.modulate)
      else $error("modulation during quick stop");
   a_precharge_edge: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == gccw_pkg::ST_READY_TO_SWITCH_ON ##1 state_q == gccw_pkg::ST_PRECHARGING)
      |-> $past(start_rise))
      else $error("precharge began without start edge");
   a_start_low_stops: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && !start && in_seq) |=> !in_seq)
      else $error("start low did not stop sequence");
   a_fault_ack_pulse: assert property (@(posedge clock) disable iff (!resetn)
      $rose(ctrl_q.fault_ack) |-> $past(evt_rise) ##1
         (!ctrl_q.fault_ack || !$past(clk_en)))
      else $error("event reset acted on a level");
   a_hold_invalid: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && wr_cmd && !wdata_q[gccw_pkg::BIT_DATA_VALID]) |=> $stable(cmd_held_q))
      else $error("invalid word was taken");

endmodule // gccw_top

// >>> dv/gccw_plant.sv
/* Power stage stand-in: answers precharge and breaker commands.
   Assumes the converter block's ctrl outputs, one clock domain. */
`timescale 1ns/1ps
module gccw_plant (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 resetn,
   // Control side
   input  wire logic                 slow,
   input  wire gccw_pkg::gccw_ctrl_s ctrl,
   output gccw_pkg::gccw_fbk_s       fbk
);
   logic [4:0] cnt_q;
   // -----------------------------------
   // Charge timer, slow mode stretches it
   // -----------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) cnt_q <= 5'h00;
      else if (!ctrl.precharge) cnt_q <= 5'h00;
      else if (cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h01;
   end
   // Link stays charged while breaker is commanded; breaker lags one cycle
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) fbk <= '0;
      else begin
         fbk.precharge_done <= (ctrl.precharge && cnt_q >= (slow ? 5'h14 : 5'h03))
            || (fbk.precharge_done && (ctrl.precharge || ctrl.main_breaker_close));
         fbk.main_breaker_closed <= ctrl.main_breaker_close;
         fbk.fault_active <= 1'b0; // No faults raised by this model
      end
   end
endmodule // gccw_plant

// >>> dv/tb.sv
/* Self-checking bench for the command word block over AXI4-Lite.
   Assumes gccw_pkg and the power stage model are compiled first. */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
   logic                 clock, resetn, slow, irq, clk_en;
   logic [7:0]           awaddr, araddr;
   logic                 awvalid, awready, wvalid, wready, bvalid, bready;
   logic                 arvalid, arready, rvalid, rready;
   logic [31:0]          wdata, rdata, rd_d;
   logic [1:0]           bresp, rresp, rd_r;
   gccw_pkg::gccw_ctrl_s ctrl;
   gccw_pkg::gccw_fbk_s  fbk;
   int                   bad_count, n_checks, seed, k, n, acks;
   logic [15:0]          eff;
   // Drops: breaker enable, switch-on, start, quick stop; bits 5,6 kept 0
   logic [31:0]          drops [4] = '{32'h40d, 32'h40e, 32'h407, 32'h40b};

   gccw_top gccw_top_inst (.clock(clock), .resetn(resetn), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fbk(fbk), .ctrl(ctrl),
      .irq(irq));
   gccw_plant gccw_plant_inst (.clock(clock), .resetn(resetn), .slow(slow),
      .ctrl(ctrl), .fbk(fbk));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Pulse counter, so a one-cycle ack is never missed by a busy task
   always @(posedge clock) if (ctrl.fault_ack === 1'b1) acks++;

   // -----------------------------------
   // Expectations and bus tasks
   // -----------------------------------
   function automatic logic [15:0] eff_exp(logic [15:0] w, logic [15:0] p, logic wd);
      return wd ? gccw_pkg::CMD_DEFAULT : (w[10] ? w : p);
   endfunction
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic hang;
      bad_count++;
      conclude;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (n > 50) hang;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      rd_r = bresp;
      @(posedge clock); // Keeps bready from being driven twice in one step
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (n > 50) hang;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge clock);
   endtask
   task automatic wait_mod(input logic e);
      n = 0;
      while (ctrl.modulate !== e) begin
         @(posedge clock);
         n++;
         if (n > 200) hang;
      end
   endtask
   task automatic startup(input logic s);
      slow <= s;
      wr(gccw_pkg::OFS_COMMAND, 32'h406); // switch-on seen low first
      wr(gccw_pkg::OFS_COMMAND, 32'h407);
      wr(gccw_pkg::OFS_COMMAND, 32'h40f); // fresh start edge
      wait_mod(1'b1);
   endtask

   // -----------------------------------
   // Main sequence
   // -----------------------------------
   initial begin
      seed = 32'h6e3d39c4; bad_count = 0; n_checks = 0; acks = 0; resetn = 1'b0;
      slow = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
      clk_en = 1'b1;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rd(gccw_pkg::OFS_COMMAND); `CHK(rd_d, 32'h5)
      rd(gccw_pkg::OFS_STATUS);  `CHK(rd_d, 32'h0005_0000)
      rd(8'h14);                 `CHK(rd_r, gccw_pkg::RESP_SLVERR)
      wr(8'h14, 32'h1);          `CHK(rd_r, gccw_pkg::RESP_SLVERR)
      for (k = 0; k < 4; k++) begin
         eff = 16'($random(seed));
         wr(gccw_pkg::OFS_MASK, {28'h0, eff[3:0]}); `CHK(rd_r, gccw_pkg::RESP_OKAY)
         rd(gccw_pkg::OFS_MASK); `CHK(rd_d, {28'h0, eff[3:0]})
      end
      // Start already high when switching on: no edge, no charge
      wr(gccw_pkg::OFS_COMMAND, 32'h40e);
      wr(gccw_pkg::OFS_COMMAND, 32'h40f);
      repeat (8) @(posedge clock);
      `CHK(ctrl.precharge, 1'b0)
      wr(gccw_pkg::OFS_MASK, 32'h2);
      for (k = 0; k < 4; k++) begin
         // Later passes also demand an armed start edge
         wr(gccw_pkg::OFS_CONFIG, 32'h4 | k[1]);
         startup(k[0]);
         rd(gccw_pkg::OFS_STATUS); `CHK(rd_d[2:0], 3'h4)
         if (k == 2) begin
            // Frozen block keeps running and refuses the bus
            clk_en <= 1'b0;
            repeat (4) @(posedge clock);
            `CHK(ctrl.modulate, 1'b1)
            `CHK(arready, 1'b0)
            clk_en <= 1'b1;
         end
         wr(gccw_pkg::OFS_COMMAND, drops[k]);
         `CHK(ctrl.modulate, 1'b0)
         if (k < 2) begin
            repeat (2) @(posedge clock);
            `CHK(ctrl.main_breaker_close, 1'b0)
         end
         if (k == 0) begin
            rd(gccw_pkg::OFS_STATUS); `CHK(rd_d[2:0], 3'h0)
         end
      end
      `CHK(ctrl.exception, 1'b1)
      `CHK(irq, 1'b1)
      wr(gccw_pkg::OFS_COMMAND, 32'h407);
      wr(gccw_pkg::OFS_EVENT, 32'hf);
      `CHK(irq, 1'b0)
      // Application owns precharge through bit 4
      wr(gccw_pkg::OFS_CONFIG, 32'h2);
      wr(gccw_pkg::OFS_COMMAND, 32'h417);
      `CHK(ctrl.precharge, 1'b1)
      wr(gccw_pkg::OFS_COMMAND, 32'h407);
      `CHK(ctrl.precharge, 1'b0)
      acks = 0;
      wr(gccw_pkg::OFS_COMMAND, 32'h487);
      wr(gccw_pkg::OFS_COMMAND, 32'h487);
      repeat (4) @(posedge clock);
      `CHK(acks, 1)
      rd(gccw_pkg::OFS_EVENT); `CHK(rd_d[0], 1'b1)
      rd(gccw_pkg::OFS_STATUS); `CHK(rd_d[31:16], 16'h0487)
      eff = 16'h0487;
      wr(gccw_pkg::OFS_COMMAND, 32'h006);
      rd(gccw_pkg::OFS_STATUS); `CHK(rd_d[31:16], eff_exp(16'h006, eff, 1'b0))
      wr(gccw_pkg::OFS_CONFIG, 32'h8);
      rd(gccw_pkg::OFS_STATUS); `CHK(rd_d[31:16], eff_exp(16'h006, eff, 1'b1))
      conclude;
   end
endmodule // tb
